// File: core/bib_cfg.svh
`ifndef BIB_CFG_SVH
`define BIB_CFG_SVH

`define BIB_ADDR_W      8
`define BIB_DATA_W      32
`define BIB_OFS_OPTS    8'h20
`define BIB_OFS_ID_HI   8'h24
`define BIB_OFS_ID_LO   8'h28
`define BIB_OFS_CTRL    8'h2c
`define BIB_OFS_STAT    8'h30

`define BIB_BMC_BIT     28
`define BIB_PMC_BIT     27
`define BIB_ACC_HI      23
`define BIB_ACC_LO      16
`define BIB_MREC_HI     15
`define BIB_MREC_LO     12
`define BIB_GEN_HI      7
`define BIB_GEN_LO      6
`define BIB_SPD_HI      2
`define BIB_SPD_LO      0

`define BIB_ACC_RST     8'h00
`define BIB_MREC_RST    4'ha
`define BIB_MREC_MIN    4'h8
`define BIB_GEN_RST     2'h0
`define BIB_SPD_VAL     3'h2
`define BIB_ID_RST      32'h0000_0000
`define BIB_LEN_W       16

`define BIB_RESP_OKAY   2'h0
`define BIB_RESP_SLVERR 2'h2

`endif

// File: core/bib_pkg.sv
`include "bib_cfg.svh"

package bib_pkg;

  typedef struct packed {
    logic                       bmc;
    logic                       pmc;
    logic [7:0]                 clk_acc;
    logic [3:0]                 max_rec;
    logic [1:0]                 gen;
  } bib_opts_s;

  typedef struct packed {
    logic                       valid;
    logic                       sel;
    logic [`BIB_DATA_W-1:0]     data;
  } bib_ee_load_s;

  typedef struct packed {
    logic                       valid;
    logic [`BIB_LEN_W-1:0]      len;
  } bib_rx_req_s;

  typedef enum {
    REG_OPTS,
    REG_ID_HI,
    REG_ID_LO,
    REG_CTRL,
    REG_STAT,
    REG_NONE
  } bib_reg_e;

endpackage : bib_pkg

// File: core/bib_id_slot.sv
`include "bib_cfg.svh"

module bib_id_slot (
  input  wire logic                   aclk,
  input  wire logic                   global_reset_n,
  input  wire logic                   load_en,
  input  wire logic [`BIB_DATA_W-1:0] load_data,
  output logic      [`BIB_DATA_W-1:0] value_q,
  output logic                        locked_q
);

  // Only the global reset clears the word; the soft reset leaves it.
  always_ff @(posedge aclk) begin
    if (!global_reset_n) begin
      value_q <= `BIB_ID_RST;
    end else if (load_en && !locked_q) begin
      value_q <= load_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!global_reset_n) begin
      locked_q <= 1'b0;
    end else if (load_en) begin
      locked_q <= 1'b1;
    end
  end

  a_slot_frozen: assert property (
    @(posedge aclk) disable iff (!global_reset_n)
    locked_q |=> $stable(value_q) && locked_q)
    else $error("identifier word changed after lock");

endmodule : bib_id_slot

// File: core/bib_regs.sv
// Contract
// - Bus-manager-capable flag, bit 28, RW, zero default.
// - Power-management-capable flag, bit 27, RW, zero default.
// - Bits 26 to 24 ignore writes, read zero.
// - Clock accuracy byte, bits 23:16, RW, zero.
// - Max request code gives 2^(code+1), at least 512.
// - Max request code is A, cleared by global reset only.
// - Oversized block write may raise type-error acknowledge.
// - Bits 11 to 8 read zero.
// - Generation counter bumps when ROM changed since reset.
// - Bits 5 to 3 read zero.
// - Link speed field always reads binary 010.
// - Upper identifier word read-only, global reset clears.
// - EEPROM present: loader fills identifier, then locked.
// - No EEPROM: firmware fills identifier once, then locked.
// - Lower identifier word behaves like the upper one.
//
// Decided for this implementation: register access over AXI4-Lite.
`include "bib_cfg.svh"

module bib_regs (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    global_reset_n,
  input  wire logic                    eeprom_present,
  input  wire bib_pkg::bib_ee_load_s   ee_load,
  input  wire logic                    rom_changed,
  input  wire logic                    bus_reset,
  input  wire bib_pkg::bib_rx_req_s    rx_req,
  output logic                         ack_type_error_q,
  output bib_pkg::bib_opts_s           opts_q,
  output logic                         link_on_q,
  output logic [`BIB_DATA_W-1:0]       id_upper,
  output logic [`BIB_DATA_W-1:0]       id_lower,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [`BIB_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [`BIB_DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [`BIB_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [`BIB_DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                   s_axi_rresp
);

  function automatic bib_pkg::bib_reg_e reg_decode(
    input logic [`BIB_ADDR_W-1:0] addr
  );
    case (addr)
      `BIB_OFS_OPTS:  reg_decode = bib_pkg::REG_OPTS;
      `BIB_OFS_ID_HI: reg_decode = bib_pkg::REG_ID_HI;
      `BIB_OFS_ID_LO: reg_decode = bib_pkg::REG_ID_LO;
      `BIB_OFS_CTRL:  reg_decode = bib_pkg::REG_CTRL;
      `BIB_OFS_STAT:  reg_decode = bib_pkg::REG_STAT;
      default:        reg_decode = bib_pkg::REG_NONE;
    endcase
  endfunction : reg_decode

  logic                    sys_rst;
  logic                    aw_hold_q;
  logic [`BIB_ADDR_W-1:0]  aw_addr_q;
  logic                    w_hold_q;
  logic [`BIB_DATA_W-1:0]  w_data_q;
  logic [3:0]              w_strb_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic [1:0]              bresp_d;
  logic                    rvalid_q;
  logic [`BIB_DATA_W-1:0]  rdata_q;
  logic [1:0]              rresp_q;
  logic [`BIB_DATA_W-1:0]  rdata_d;
  logic [1:0]              rresp_d;
  logic                    wr_go;
  logic                    rd_go;
  bib_pkg::bib_reg_e       wr_sel;
  logic                    id_wr_ok;
  logic                    rom_dirty_q;
  logic                    gen_wr;
  logic [16:0]             max_bytes;
  logic [1:0]              slot_ld;
  logic [1:0]              slot_lock;
  logic [`BIB_DATA_W-1:0]  slot_data [2];
  logic [`BIB_DATA_W-1:0]  slot_val  [2];
  logic                    bmc_q;
  logic                    pmc_q;
  logic [7:0]              clk_acc_q;
  logic [3:0]              max_rec_q;
  logic [1:0]              gen_q;

  assign sys_rst = !aresetn || !global_reset_n;

  // Each field has its own register so that one process owns each.
  assign opts_q = {bmc_q, pmc_q, clk_acc_q, max_rec_q, gen_q};

  // Write address and data are taken in either order and held until
  // both have arrived; the response channel blocks new ones.
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign wr_go         = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_sel        = reg_decode(aw_addr_q);
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (sys_rst) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (sys_rst) begin
      w_hold_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_hold_q <= 1'b0;
    end
  end

  // A firmware load of an identifier word must be a full-word write.
  assign id_wr_ok = !eeprom_present && (w_strb_q == 4'hf);

  always_comb begin
    bresp_d = `BIB_RESP_OKAY;
    unique case (wr_sel)
      bib_pkg::REG_ID_HI: begin
        if (!id_wr_ok || slot_lock[1]) begin
          bresp_d = `BIB_RESP_SLVERR;
        end
      end
      bib_pkg::REG_ID_LO: begin
        if (!id_wr_ok || slot_lock[0]) begin
          bresp_d = `BIB_RESP_SLVERR;
        end
      end
      bib_pkg::REG_NONE: bresp_d = `BIB_RESP_SLVERR;
      bib_pkg::REG_OPTS,
      bib_pkg::REG_CTRL,
      bib_pkg::REG_STAT: bresp_d = `BIB_RESP_OKAY;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `BIB_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= bresp_d;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Capability flags and clock accuracy follow either reset.
  always_ff @(posedge aclk) begin
    if (sys_rst) begin
      bmc_q     <= 1'b0;
      pmc_q     <= 1'b0;
      clk_acc_q <= `BIB_ACC_RST;
    end else if (wr_go && wr_sel == bib_pkg::REG_OPTS) begin
      if (w_strb_q[3]) begin
        bmc_q <= w_data_q[`BIB_BMC_BIT];
        pmc_q <= w_data_q[`BIB_PMC_BIT];
      end
      if (w_strb_q[2]) begin
        clk_acc_q <= w_data_q[`BIB_ACC_HI:`BIB_ACC_LO];
      end
    end
  end

  // Codes under the 512-byte floor are dropped rather than stored.
  always_ff @(posedge aclk) begin
    if (!global_reset_n) begin
      max_rec_q <= `BIB_MREC_RST;
    end else if (aresetn && wr_go && wr_sel == bib_pkg::REG_OPTS &&
                 w_strb_q[1] &&
                 w_data_q[`BIB_MREC_HI:`BIB_MREC_LO] >= `BIB_MREC_MIN) begin
      max_rec_q <= w_data_q[`BIB_MREC_HI:`BIB_MREC_LO];
    end
  end

  assign gen_wr = wr_go && wr_sel == bib_pkg::REG_OPTS && w_strb_q[0];

  // A ROM change in the same cycle as a bus reset is kept for the
  // next generation rather than lost.
  always_ff @(posedge aclk) begin
    if (sys_rst) begin
      rom_dirty_q <= 1'b0;
    end else if (rom_changed) begin
      rom_dirty_q <= 1'b1;
    end else if (bus_reset) begin
      rom_dirty_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (sys_rst) begin
      gen_q <= `BIB_GEN_RST;
    end else if (gen_wr) begin
      gen_q <= w_data_q[`BIB_GEN_HI:`BIB_GEN_LO];
    end else if (bus_reset && rom_dirty_q) begin
      gen_q <= gen_q + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (sys_rst) begin
      link_on_q <= 1'b0;
    end else if (wr_go && wr_sel == bib_pkg::REG_CTRL && w_strb_q[0]) begin
      link_on_q <= w_data_q[0];
    end
  end

  // The shift amount is five bits wide so that code 15 gives 2^16.
  assign max_bytes = 17'h1 << ({1'b0, max_rec_q} + 5'h01);

  always_ff @(posedge aclk) begin
    if (sys_rst) begin
      ack_type_error_q <= 1'b0;
    end else begin
      ack_type_error_q <= rx_req.valid &&
                          ({1'b0, rx_req.len} > max_bytes);
    end
  end

  // The loader owns the identifier words when an EEPROM is fitted;
  // otherwise a full-word bus write from firmware fills them.
  assign slot_data[1] = eeprom_present ? ee_load.data : w_data_q;
  assign slot_data[0] = eeprom_present ? ee_load.data : w_data_q;
  assign slot_ld[1]   = eeprom_present ?
                        (ee_load.valid && ee_load.sel == 1'b1) :
                        (wr_go && wr_sel == bib_pkg::REG_ID_HI &&
                         id_wr_ok);
  assign slot_ld[0]   = eeprom_present ?
                        (ee_load.valid && ee_load.sel == 1'b0) :
                        (wr_go && wr_sel == bib_pkg::REG_ID_LO &&
                         id_wr_ok);

  for (genvar i = 0; i < 2; i++) begin : g_slot
    bib_id_slot u_slot (
      .aclk           (aclk),
      .global_reset_n (global_reset_n),
      .load_en        (slot_ld[i]),
      .load_data      (slot_data[i]),
      .value_q        (slot_val[i]),
      .locked_q       (slot_lock[i])
    );
  end

  assign id_upper = slot_val[1];
  assign id_lower = slot_val[0];

  // Read channel: one read in flight, answered on the next edge.
  assign s_axi_arready = !rvalid_q;
  assign rd_go         = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    rdata_d = '0;
    rresp_d = `BIB_RESP_OKAY;
    unique case (reg_decode(s_axi_araddr))
      bib_pkg::REG_OPTS: begin
        rdata_d[`BIB_BMC_BIT]             = opts_q.bmc;
        rdata_d[`BIB_PMC_BIT]             = opts_q.pmc;
        rdata_d[`BIB_ACC_HI:`BIB_ACC_LO]  = opts_q.clk_acc;
        rdata_d[`BIB_MREC_HI:`BIB_MREC_LO] = opts_q.max_rec;
        rdata_d[`BIB_GEN_HI:`BIB_GEN_LO]  = opts_q.gen;
        rdata_d[`BIB_SPD_HI:`BIB_SPD_LO]  = `BIB_SPD_VAL;
      end
      bib_pkg::REG_ID_HI: rdata_d = slot_val[1];
      bib_pkg::REG_ID_LO: rdata_d = slot_val[0];
      bib_pkg::REG_CTRL:  rdata_d[0] = link_on_q;
      bib_pkg::REG_STAT: begin
        rdata_d[0] = slot_lock[1];
        rdata_d[1] = slot_lock[0];
        rdata_d[2] = eeprom_present;
        rdata_d[3] = rom_dirty_q;
      end
      bib_pkg::REG_NONE: rresp_d = `BIB_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `BIB_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (sys_rst);

  a_cap_write: assert property (
    wr_go && wr_sel == bib_pkg::REG_OPTS && w_strb_q[3] && w_strb_q[2]
    |=> opts_q.bmc == $past(w_data_q[`BIB_BMC_BIT]) &&
        opts_q.pmc == $past(w_data_q[`BIB_PMC_BIT]) &&
        opts_q.clk_acc == $past(w_data_q[`BIB_ACC_HI:`BIB_ACC_LO]))
    else $error("capability fields did not take the write");

  a_opts_fixed: assert property (
    rd_go && reg_decode(s_axi_araddr) == bib_pkg::REG_OPTS
    |=> s_axi_rvalid && s_axi_rdata[31:29] == 3'h0 &&
        s_axi_rdata[26:24] == 3'h0 && s_axi_rdata[11:8] == 4'h0 &&
        s_axi_rdata[5:3] == 3'h0 && s_axi_rdata[2:0] == 3'b010)
    else $error("fixed bus option bits read wrong");

  a_mrec_floor: assert property (
    opts_q.max_rec >= 4'h8)
    else $error("maximum request below 512 bytes");

  a_mrec_soft: assert property (
    @(posedge aclk) disable iff (!global_reset_n)
    !aresetn |=> $stable(opts_q.max_rec))
    else $error("soft reset disturbed maximum request");

  a_global_reset_n_clear: assert property (
    @(posedge aclk) disable iff (1'b0)
    !global_reset_n |=> opts_q.max_rec == 4'ha &&
                        id_upper == 32'h0 && id_lower == 32'h0 &&
                        slot_lock == 2'b00)
    else $error("global reset did not clear the words");

  a_oversize_ack: assert property (
    rx_req.valid && {1'b0, rx_req.len} > max_bytes
    |=> ack_type_error_q)
    else $error("oversized block write not flagged");

  a_gen_bump: assert property (
    bus_reset && rom_dirty_q && !gen_wr
    |=> opts_q.gen == $past(opts_q.gen) + 2'h1)
    else $error("generation did not advance");

  a_ee_refuse: assert property (
    wr_go && eeprom_present &&
    (wr_sel == bib_pkg::REG_ID_HI || wr_sel == bib_pkg::REG_ID_LO)
    |=> s_axi_bvalid && s_axi_bresp == 2'h2 && $stable(id_upper) &&
        $stable(id_lower))
    else $error("bus write reached identifier with EEPROM");

  a_fw_once: assert property (
    slot_ld[1] && !slot_lock[1]
    |=> slot_lock[1] && id_upper == $past(slot_data[1]))
    else $error("first identifier load not taken and locked");

endmodule : bib_regs

// File: bench/bib_ee_model.sv
module bib_ee_model (
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic [31:0] up_word,
  input  wire logic [31:0] lo_word,
  output bib_pkg::bib_ee_load_s ee_load
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]            step_q = 2'h0;
  bib_pkg::bib_ee_load_s ld_q   = '0;
  assign ee_load = ld_q;
  // The loader sends the upper word, then the lower word, once per start.
  always @(posedge aclk) begin
    case (step_q)
      2'h1: ld_q <= '{1'b1, 1'b1, up_word};
      2'h2: ld_q <= '{1'b1, 1'b0, lo_word};
      // Released data lines show the inverse of the last value.
      default: ld_q <= '{1'b0, 1'b0, ~ld_q.data};
    endcase
    step_q <= (go || step_q != 2'h0) ? step_q + 2'h1 : 2'h0;
  end
endmodule : bib_ee_model

// File: bench/tb_bus_info_block_regs.sv
`include "bib_cfg.svh"

module tb_bus_info_block_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, global_reset_n, eeprom_present;
  logic        rom_changed, bus_reset, go, ack_type_error_q, link_on_q;
  logic [31:0] up_word, lo_word, id_upper, id_lower;
  bib_pkg::bib_ee_load_s ee_load;
  bib_pkg::bib_rx_req_s  rx_req;
  bib_pkg::bib_opts_s    opts_q;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          fail_count = 0;
  int          comparisons = 0;

  bib_regs uut (
    .aclk(aclk), .aresetn(aresetn), .global_reset_n(global_reset_n),
    .eeprom_present(eeprom_present), .ee_load(ee_load),
    .rom_changed(rom_changed), .bus_reset(bus_reset), .rx_req(rx_req),
    .ack_type_error_q(ack_type_error_q), .opts_q(opts_q),
    .link_on_q(link_on_q), .id_upper(id_upper), .id_lower(id_lower),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp)
  );

  bib_ee_model ee (
    .aclk(aclk), .go(go), .up_word(up_word), .lo_word(lo_word),
    .ee_load(ee_load)
  );

  task automatic results;
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask : rd

  task automatic rst(input logic g);
    if (g) global_reset_n <= 1'b0;
    else aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    global_reset_n <= 1'b1;
    @(posedge aclk);
  endtask : rst

  task automatic pulse(input logic [2:0] m);
    {go, bus_reset, rom_changed} <= m;
    @(posedge aclk);
    {go, bus_reset, rom_changed} <= 3'h0;
    repeat (5) @(posedge aclk);
  endtask : pulse

  task automatic rx(input logic [15:0] len, input logic e);
    rx_req <= '{1'b1, len};
    @(posedge aclk);
    rx_req <= '0;
    @(posedge aclk);
    chk({31'h0, ack_type_error_q}, {31'h0, e});
  endtask : rx

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    results();
  end

  initial begin
    {aresetn, global_reset_n, eeprom_present} = 3'h0;
    {rom_changed, bus_reset, go, awvalid, wvalid, bready} = 6'h0;
    {arvalid, rready} = 2'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    rx_req = '0;
    up_word = 32'hc0de_0001;
    lo_word = 32'h5a5a_0002;
    repeat (3) @(posedge aclk);
    {aresetn, global_reset_n} <= 2'h3;
    @(posedge aclk);
    rd(8'h20, 32'h0000_a002, 2'h0);
    rd(8'h24, 32'h0, 2'h0);
    rd(8'h28, 32'h0, 2'h0);
    wr(8'h20, 32'hffff_ffff, 4'hf, 2'h0);
    rd(8'h20, 32'h18ff_f0c2, 2'h0);
    wr(8'h20, 32'h0000_7000, 4'h2, 2'h0);
    rd(8'h20, 32'h18ff_f0c2, 2'h0);
    wr(8'h20, 32'h0000_8000, 4'h2, 2'h0);
    rd(8'h20, 32'h18ff_80c2, 2'h0);
    chk({16'h0, opts_q}, 32'h0000_ffe3);
    rx(16'd512, 1'b0);
    rx(16'd513, 1'b1);
    wr(8'h2c, 32'h1, 4'hf, 2'h0);
    chk({31'h0, link_on_q}, 32'h1);
    rd(8'h2c, 32'h1, 2'h0);
    rst(1'b0);
    rd(8'h20, 32'h0000_8002, 2'h0);
    pulse(3'h1);
    pulse(3'h2);
    rd(8'h20, 32'h0000_8042, 2'h0);
    pulse(3'h2);
    rd(8'h20, 32'h0000_8042, 2'h0);
    wr(8'h24, 32'h1234_5678, 4'hf, 2'h0);
    chk(id_upper, 32'h1234_5678);
    wr(8'h24, 32'h0, 4'hf, 2'h2);
    rd(8'h24, 32'h1234_5678, 2'h0);
    wr(8'h28, 32'habcd_0000, 4'h3, 2'h2);
    wr(8'h28, 32'h9abc_def0, 4'hf, 2'h0);
    rd(8'h28, 32'h9abc_def0, 2'h0);
    chk(id_lower, 32'h9abc_def0);
    rd(8'h30, 32'h3, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h1, 4'hf, 2'h2);
    rst(1'b1);
    rd(8'h20, 32'h0000_a002, 2'h0);
    rd(8'h24, 32'h0, 2'h0);
    rd(8'h28, 32'h0, 2'h0);
    eeprom_present <= 1'b1;
    pulse(3'h4);
    rd(8'h24, 32'hc0de_0001, 2'h0);
    rd(8'h28, 32'h5a5a_0002, 2'h0);
    wr(8'h24, 32'h0, 4'hf, 2'h2);
    up_word <= 32'h1111_1111;
    pulse(3'h4);
    rd(8'h24, 32'hc0de_0001, 2'h0);
    rd(8'h30, 32'h7, 2'h0);
    results();
  end
endmodule : tb_bus_info_block_regs
